// >>> ascl_pkg.sv
// Package for the single-axis speed control loop.
// Assumes one 40 MHz clock and a host that drives the plain register port.
package ascl_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_SPEED = 4'h1;
	localparam logic [3:0] ADR_LIMIT = 4'h2;
	localparam logic [3:0] ADR_ACC = 4'h3;
	localparam logic [3:0] ADR_DEC = 4'h4;
	localparam logic [3:0] ADR_RDEC = 4'h5;
	localparam logic [3:0] ADR_SDEC = 4'h6;
	localparam logic [3:0] ADR_STAT = 4'h7;
	localparam logic [3:0] ADR_SPDNOW = 4'h8;
	localparam logic [3:0] ADR_FEED = 4'h9;
	localparam logic [3:0] ADR_CHG = 4'ha;

	// ----------------------------------------------------------------
	// Control register fields (write-one pulses except update, variant and test)
	// ----------------------------------------------------------------
	localparam int CTL_FWD = 0;
	localparam int CTL_REV = 1;
	localparam int CTL_STOP = 2;
	localparam int CTL_RSTOP = 3;
	localparam int CTL_UPD = 4;
	localparam int CTL_NEWVAR = 5;
	localparam int CTL_ALLSTOP = 6;
	localparam int CTL_TEST = 7;

	// Reset values
	localparam logic [31:0] RST_LIMIT = 32'h0000_ffff;
	localparam logic [31:0] RST_TIME = 32'h0000_03e8;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// Timing: ramp times are in milliseconds; one ms tick at 40 MHz
	localparam int CLK_KHZ = 40000;
	localparam int MS_CYC = CLK_KHZ;

	// ----------------------------------------------------------------
	// Motion states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ACCEL = 4'h2,
		ST_RUN = 4'h4,
		ST_DECEL = 4'h8
	} ascl_state_t;

	// Deceleration time selected for the current stop
	typedef enum logic [1:0] {
		DS_NORM = 2'h0,
		DS_STOPIN = 2'h1,
		DS_RAPID = 2'h2
	} ascl_dsel_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ascl_req_t;

	// Servo-side command toward the amplifier
	typedef struct packed {
		logic pos_loop_on;
		logic dir_rev;
		logic [31:0] speed;
	} ascl_servo_t;

endpackage : ascl_pkg

// >>> ascl_ramp.sv
// Ramp step generator: one speed step per millisecond tick.
// Assumes the caller holds time and span steady while a ramp runs.
`timescale 1ns/100ps
module ascl_ramp
	import ascl_pkg::*;
#(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// Ramp setup
	input wire logic [W-1:0] span,
	input wire logic [W-1:0] time_ms,
	// Tick out and step size
	output logic tick,
	output logic [W-1:0] step
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
		logic [W-1:0] step;
	} ascl_ramp_st_t;

	ascl_ramp_st_t s_q;
	ascl_ramp_st_t s_d;

	// Step per ms; a zero time means the whole span in one step
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt >= 32'(MS_CYC - 1)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 32'h1;
		end
		if (time_ms == '0)
			s_d.step = span;
		else if (span / time_ms == '0)
			s_d.step = W'(1);
		else
			s_d.step = span / time_ms;
	end

	// Register the state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign tick = s_q.tick;
	assign step = s_q.step;

endmodule : ascl_ramp

// >>> ascl_top.sv
// Speed control of one servo axis with ramps and stop handling.
// Assumes a synchronous host port and a servo amplifier that follows
// the speed and direction outputs while the position loop flag is set.
`timescale 1ns/100ps

// Notes on behaviour
// R01: Runs at commanded speed until a stop
// R02: Forward or reverse start, one axis
// R03: Position loop stays active in speed mode
// R04: Update command on: feed value tracks motion
// R05: Update command off: feed value held zero
// R06: Older variant: zero at start, held
// R07: Stop input uses stop-input deceleration time
// R08: Stop command edge uses normal deceleration
// R09: Rapid stop edge uses rapid deceleration
// R10: Rapid stop overrides ongoing normal deceleration
// R11: Test-mode all-axes stop uses rapid time
// R12: Speed change to zero decelerates normally
// R13: Host sets no dwell time here
// R14: Start ramps up over acceleration time
// R15: Zero speed ends mode, reports stopped
module ascl_top
	import ascl_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// Register port
	input wire ascl_req_t req,
	output logic [31:0] rdata,
	// External stop input, level
	input wire logic stop_in,
	// Servo side
	input wire logic [31:0] motion_delta,
	output ascl_servo_t servo,
	output logic busy
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// All registers of the block except the ramp generator's live in one record; the ramp
	// takes the same clock enable, so the enable freezes every one of them at once.
	typedef struct packed {
		// Motion phase and the stop source that set the ramp time
		ascl_state_t st;
		ascl_dsel_t dsel;
		// Speed the stop ramp started from; a stop must not slow down
		// when a zero speed change clears the commanded speed
		logic [31:0] dspan;
		// Host settings
		logic [31:0] cmd_speed;
		logic [31:0] limit;
		logic [31:0] acc_t;
		logic [31:0] dec_t;
		logic [31:0] rdec_t;
		logic [31:0] sdec_t;
		// Live motion values
		logic [31:0] speed;
		logic [31:0] feed;
		logic dir_rev;
		logic upd_cmd;
		logic new_var;
		logic test_mode;
		logic stop_in_q;
		// Registered copies of the outputs
		logic [31:0] rdata;
		ascl_servo_t servo;
		logic busy;
	} ascl_st_t;

	ascl_st_t s_q;
	ascl_st_t s_d;

	// Ramp step source
	logic tick;
	logic [31:0] step;
	logic [31:0] ramp_time;
	logic [31:0] ramp_span;

	// Clamp a speed to the limit
	function automatic logic [31:0] clamp(input logic [31:0] v,
		input logic [31:0] lim);
		clamp = (v > lim) ? lim : v;
	endfunction : clamp

	// Ramp time follows the phase and the chosen deceleration.
	// The ramp step is registered, so idle already presents the
	// acceleration setup; the first accelerating cycle then sees
	// the right step.
	always_comb begin
		// Stops ramp down from the latched start speed
		if (s_q.st == ST_DECEL)
			ramp_span = s_q.dspan;
		else
			ramp_span = clamp(s_q.cmd_speed, s_q.limit);
		case (s_q.dsel)
			DS_RAPID: ramp_time = s_q.rdec_t;
			DS_STOPIN: ramp_time = s_q.sdec_t;
			default: ramp_time = s_q.dec_t;
		endcase
		// Idle and accelerating both use the acceleration time
		if (s_q.st == ST_ACCEL || s_q.st == ST_IDLE)
			ramp_time = s_q.acc_t;
	end

	ascl_ramp #(.W(32)) u_ramp (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.span(ramp_span),
		.time_ms(ramp_time),
		.tick(tick),
		.step(step)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic wr_ctl;
		logic start;
		logic stop_cmd;
		logic rstop;
		logic moving;
		logic [31:0] tgt;
		logic go;
		logic chg_zero;
		wr_ctl = req.wr && (req.addr == ADR_CTRL);
		s_d = s_q;
		// Start and stop requests decoded from the control word
		start = wr_ctl && (req.wdata[CTL_FWD] || req.wdata[CTL_REV]);
		stop_cmd = wr_ctl && req.wdata[CTL_STOP];
		rstop = wr_ctl && (req.wdata[CTL_RSTOP] ||
			(req.wdata[CTL_ALLSTOP] && s_q.test_mode));
		moving = (s_q.st != ST_IDLE);
		tgt = clamp(s_q.cmd_speed, s_q.limit);
		// A zero ramp time acts at once instead of on the ms tick
		go = tick || (ramp_time == '0);
		chg_zero = req.wr && (req.addr == ADR_CHG) &&
			(req.wdata == '0);
		s_d.stop_in_q = stop_in;

		// Configuration writes; dwell has no register at all
		// R13: no dwell field
		if (req.wr) begin
			case (req.addr)
				ADR_CTRL: begin
					s_d.upd_cmd = req.wdata[CTL_UPD];
					s_d.new_var = req.wdata[CTL_NEWVAR];
					s_d.test_mode = req.wdata[CTL_TEST];
				end
				ADR_SPEED: s_d.cmd_speed = req.wdata;
				ADR_LIMIT: s_d.limit = req.wdata;
				ADR_ACC: s_d.acc_t = req.wdata;
				ADR_DEC: s_d.dec_t = req.wdata;
				ADR_RDEC: s_d.rdec_t = req.wdata;
				ADR_SDEC: s_d.sdec_t = req.wdata;
				// Speed change; a zero value is acted on by the
				// sequencer so that it ranks with the other stops
				ADR_CHG: s_d.cmd_speed = req.wdata;
				default: ;
			endcase
		end

		// Motion sequencer
		case (s_q.st)
			ST_IDLE: begin
				// R02: start one axis
				if (start) begin
					s_d.st = ST_ACCEL;
					s_d.dir_rev = !req.wdata[CTL_FWD];
					s_d.speed = '0;
					s_d.dsel = DS_NORM;
					// R06: zero at start
					s_d.feed = '0;
				end
			end
			ST_ACCEL, ST_RUN: begin
				// R14: ramp to target
				// Compare the gap, not the sum, so a large step
				// cannot wrap past the target
				if (go && s_q.st == ST_ACCEL) begin
					if (s_q.speed >= tgt ||
						step >= tgt - s_q.speed) begin
						s_d.speed = tgt;
						s_d.st = ST_RUN;
					end else begin
						s_d.speed = s_q.speed + step;
					end
				end
				// R01: hold speed, follow limit
				if (s_q.st == ST_RUN)
					s_d.speed = tgt;
				// R09: rapid stop edge
				if (rstop) begin
					s_d.st = ST_DECEL;
					s_d.dsel = DS_RAPID;
				// R08: stop command edge
				end else if (stop_cmd) begin
					s_d.st = ST_DECEL;
					s_d.dsel = DS_NORM;
				// R07: stop input rises
				end else if (stop_in && !s_q.stop_in_q) begin
					s_d.st = ST_DECEL;
					s_d.dsel = DS_STOPIN;
				// R12: zero speed stops
				end else if (chg_zero) begin
					s_d.st = ST_DECEL;
					s_d.dsel = DS_NORM;
				end
			end
			ST_DECEL: begin
				// R10: rapid overrides
				// R11: all-axes stop
				if (rstop)
					s_d.dsel = DS_RAPID;
				// R15: stopped at zero
				// With a zero time the stop ends between ticks
				if (go) begin
					if (s_q.speed <= step) begin
						s_d.speed = '0;
						s_d.st = ST_IDLE;
					end else begin
						s_d.speed = s_q.speed - step;
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase

		// R10: latch the ramp start speed
		// Each new stop, and a rapid override of a running stop,
		// ramps down from the speed of this very cycle
		if (s_d.st == ST_DECEL &&
			(s_q.st != ST_DECEL || s_d.dsel != s_q.dsel))
			s_d.dspan = s_q.speed;

		// Feed current value
		// Outside a run the value is kept for the host to read
		if (moving) begin
			// R04: tracks motion
			if (s_q.new_var && s_q.upd_cmd)
				s_d.feed = s_q.feed + motion_delta;
			// R05: held zero
			else if (s_q.new_var)
				s_d.feed = '0;
			// R06: older variant never tracks
			else
				s_d.feed = '0;
		end

		// Read data, one cycle later
		// Unmapped addresses and idle cycles read as zero
		s_d.rdata = '0;
		if (req.rd) begin
			case (req.addr)
				ADR_CTRL: s_d.rdata = {24'h0, s_q.test_mode, 1'b0,
					s_q.new_var, s_q.upd_cmd, 4'h0};
				ADR_SPEED: s_d.rdata = s_q.cmd_speed;
				ADR_LIMIT: s_d.rdata = s_q.limit;
				ADR_ACC: s_d.rdata = s_q.acc_t;
				ADR_DEC: s_d.rdata = s_q.dec_t;
				ADR_RDEC: s_d.rdata = s_q.rdec_t;
				ADR_SDEC: s_d.rdata = s_q.sdec_t;
				ADR_STAT: s_d.rdata = {24'h0, 2'h0, s_q.dsel,
					s_q.st};
				ADR_SPDNOW: s_d.rdata = s_q.speed;
				ADR_FEED: s_d.rdata = s_q.feed;
				default: s_d.rdata = '0;
			endcase
		end

		// Servo outputs
		// Taken from the next state so they line up with busy
		// R03: position loop active
		s_d.servo.pos_loop_on = (s_d.st != ST_IDLE);
		s_d.servo.dir_rev = s_d.dir_rev;
		s_d.servo.speed = s_d.speed;
		s_d.busy = (s_d.st != ST_IDLE);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Zero all, then the default limit and ramp times
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.limit <= RST_LIMIT;
			s_q.acc_t <= RST_TIME;
			s_q.dec_t <= RST_TIME;
			s_q.rdec_t <= RST_TIME;
			s_q.sdec_t <= RST_TIME;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign servo = s_q.servo;
	assign busy = s_q.busy;

endmodule : ascl_top

// >>> ascl_amp.sv
// Servo amplifier model for one axis.
// Assumes one clock; returns one cycle of travel per clock.
`timescale 1ns/100ps
module ascl_amp
	import ascl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Command in, travel out
	input wire ascl_servo_t servo,
	output logic [31:0] motion_delta = 32'h0
);
	always @(posedge clk) begin
		if (servo.pos_loop_on)
			motion_delta <= servo.dir_rev ? -servo.speed : servo.speed;
		else
			motion_delta <= 32'h0;
	end
endmodule : ascl_amp

// >>> ascl_chk_props.sv
// Port checker for the speed loop.
// Assumes binding onto ascl_top, one clock.
`timescale 1ns/100ps
module ascl_chk
	import ascl_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire ascl_req_t req,
	input wire logic stop_in,
	input wire ascl_servo_t servo,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Control write with bit b
	sequence s_ctl(int b);
		ce && req.wr && req.addr == ADR_CTRL && req.wdata[b];
	endsequence
	// Idle, no start bit on the bus
	sequence s_calm;
		!busy && !req.wdata[CTL_FWD] && !req.wdata[CTL_REV];
	endsequence
	a_loop_busy: assert property (servo.pos_loop_on == busy)
		else $error("loop flag off");
	a_fwd_start: assert property (!busy && !req.wdata[CTL_REV] ##0
		s_ctl(CTL_FWD) |=> busy && !servo.dir_rev) else $error("no fwd");
	a_rev_start: assert property (!busy && !req.wdata[CTL_FWD] ##0
		s_ctl(CTL_REV) |=> busy && servo.dir_rev) else $error("no rev");
	a_no_start: assert property (s_calm |=> !busy)
		else $error("stray start");
	a_idle_stop: assert property (s_calm ##0 s_ctl(CTL_STOP) |=> !busy)
		else $error("idle stop");
	a_dir_held: assert property (busy && $past(busy) |->
		$stable(servo.dir_rev)) else $error("dir moved");
	a_idle_zero: assert property (!busy |-> servo.speed == 32'h0)
		else $error("idle speed");
	// Helper: a stop was taken in this run, so the axis may halt
	logic stop_seen_q;
	logic stop_in_prev_q;
	logic stop_evt;
	assign stop_evt = (stop_in && !stop_in_prev_q) ||
		(req.wr && req.addr == ADR_CTRL &&
		(req.wdata[CTL_STOP] || req.wdata[CTL_RSTOP] ||
		req.wdata[CTL_ALLSTOP])) ||
		(req.wr && req.addr == ADR_CHG && req.wdata == 32'h0);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stop_seen_q <= 1'b0;
			stop_in_prev_q <= 1'b0;
		end else if (ce) begin
			stop_in_prev_q <= stop_in;
			if (busy && stop_evt)
				stop_seen_q <= 1'b1;
			else if (!busy)
				stop_seen_q <= 1'b0;
		end
	end
	a_chg_run: assert property (busy && !stop_seen_q && ce &&
		!(stop_in && !stop_in_prev_q) && req.wr &&
		req.addr == ADR_CHG && req.wdata != 32'h0 |=> busy)
		else $error("change stopped");
endmodule : ascl_chk

bind ascl_top ascl_chk u_chk (.clk(clk), .rst_b(rst_b), .ce(ce),
	.req(req), .stop_in(stop_in), .servo(servo), .busy(busy));

// >>> ascl_top_test.sv
// Bench for the speed loop through its register port.
// Assumes the amplifier model returns travel every cycle.
`timescale 1ns/100ps
module ascl_top_test
	import ascl_pkg::*;
;
	// Bench signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic stop_in = 1'b0;
	ascl_req_t req = '0;
	logic [31:0] rdata;
	logic [31:0] delta;
	ascl_servo_t servo;
	logic busy;
	logic [31:0] v;
	int n_mismatch = 0;
	int checks = 0;

	// Clock, 25 ns period
	always #12.5 clk = ~clk;

	ascl_top u_ascl_top (.clk(clk), .rst_b(rst_b), .ce(ce), .req(req),
		.rdata(rdata), .stop_in(stop_in), .motion_delta(delta),
		.servo(servo), .busy(busy));
	ascl_amp u_ascl_amp (.clk(clk), .servo(servo), .motion_delta(delta));

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk

	// One write, then a quiet cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	// One read, data checked mid-cycle
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
		@(posedge clk);
	endtask : rd

	// Direction and mode flag
	task automatic pb(input logic [1:0] e);
		@(negedge clk);
		chk({30'h0, servo.dir_rev & busy, busy}, {30'h0, e});
		@(posedge clk);
	endtask : pb

	// Counts and verdict
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// Hang guard, about 60000 cycles
	initial begin
		#1500000;
		n_mismatch++;
		print_verdict();
	end

	// Test sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(ADR_LIMIT, RST_LIMIT);
		rd(ADR_SDEC, RST_TIME);
		rd(4'hf, RST_ZERO);
		for (int i = 3; i < 7; i++)
			wr(4'(i), RST_ZERO);
		wr(ADR_SPEED, 32'h64);
		$display("done: reset values");
		wr(ADR_CTRL, 32'h31);
		pb(2'b01);
		rd(ADR_SPDNOW, 32'h64);
		req.addr <= ADR_FEED;
		req.rd <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		v = rdata;
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		chk(rdata - v, 32'h64);
		repeat (40) @(posedge clk);
		pb(2'b01);
		wr(ADR_CTRL, 32'h20);
		rd(ADR_FEED, RST_ZERO);
		wr(ADR_CHG, 32'h32);
		pb(2'b01);
		wr(ADR_CHG, RST_ZERO);
		pb(2'b00);
		rd(ADR_SPDNOW, RST_ZERO);
		$display("done: forward run");
		wr(ADR_CTRL, 32'h31);
		wr(ADR_CTRL, 32'h24);
		pb(2'b00);
		rd(ADR_STAT, 32'h01);
		wr(ADR_CTRL, 32'h24);
		pb(2'b00);
		wr(ADR_DEC, 32'h1);
		wr(ADR_CTRL, 32'h32);
		pb(2'b11);
		wr(ADR_CTRL, 32'h24);
		rd(ADR_STAT, 32'h08);
		wr(ADR_CTRL, 32'h28);
		pb(2'b00);
		rd(ADR_STAT, 32'h21);
		wr(ADR_DEC, RST_ZERO);
		$display("done: stop commands");
		wr(ADR_CTRL, 32'h31);
		stop_in <= 1'b1;
		repeat (3) @(posedge clk);
		pb(2'b00);
		stop_in <= 1'b0;
		rd(ADR_STAT, 32'h11);
		wr(ADR_CTRL, 32'hb1);
		wr(ADR_CTRL, 32'he0);
		pb(2'b00);
		rd(ADR_STAT, 32'h21);
		$display("done: stop sources");
		wr(ADR_SPEED, 32'h64);
		wr(ADR_CTRL, 32'h11);
		rd(ADR_FEED, RST_ZERO);
		wr(ADR_CTRL, 32'h04);
		wr(ADR_ACC, 32'h1);
		wr(ADR_CTRL, 32'h21);
		rd(ADR_STAT, 32'h02);
		repeat (40010) @(posedge clk);
		rd(ADR_STAT, 32'h04);
		rd(ADR_SPDNOW, 32'h64);
		wr(ADR_LIMIT, 32'h40);
		rd(ADR_SPDNOW, 32'h40);
		$display("done: variant and ramp");
		print_verdict();
	end
endmodule : ascl_top_test
